//--- logic/bca_accounting.sv
// Capacity accounting core: filter, counters, compensation, display and pack supervision.
// How it works
// [RQ1] Charge above threshold counts up, lights display.
// [RQ2] Two charge updates uninterrupted declare valid charge.
// [RQ3] Valid charge counts until voltage falls below threshold.
// [RQ4] Discharge count decrements capacity, increments tally.
// [RQ5] Self-discharge decrements capacity, increments tally continuously; the code applies it as one step per day tick.
// [RQ6] Derive rate and rate-plus-temperature compensated capacities.
// [RQ7] Graphite fractions for rate and temperature reductions.
// [RQ8] Coke fractions for rate and temperature reductions.
// [RQ9] High-rate reduction holds until valid charge.
// [RQ10] Display follows rate and temperature compensated value.
// [RQ11] Below freezing, charge stops at 0.94 of full.
// [RQ12] Above freezing, charge counts to full again.
// [RQ13] Self-discharge rate doubles per ten-degree band.
// [RQ14] Strap high disables self-discharge entirely.
// [RQ15] Both filter thresholds are 250 microvolts.
// [RQ16] No counts inside the dead band.
// [RQ17] Charge FET off on overvoltage or bad temperature.
// [RQ18] Stack voltage limit register at address 15h.
// [RQ19] Protector flag sets above 2.5V, clears below 0.5V.
// [RQ20] Inaccuracy counter counts valid charges, saturates, resets.
// [RQ21] Inaccurate flag after 64 valid charges.
// [RQ22] Capacity stops rising at last measured discharge.
// [RQ23] Discharge tally saturates at FFh.
// [RQ24] Tally clears when capacity equals full.
// [RQ25] Strap picks graphite or coke table.
`timescale 1ns/1ps
module bca_accounting
   import bca_pkg::*;
#(
   parameter longint unsigned DAY_PERIOD     = DAY_CYCLES,
   parameter int unsigned     COUNT_UNIT_UV  = 4096,
   parameter int unsigned     FILTER_TIMEOUT = 64,
   parameter int unsigned     HALF_C_UV      = 25000,
   parameter logic [15:0]     LMD_INIT       = 16'h7800
)(
   input  wire logic               clk_i,
   input  wire logic               reset_n_i,
   input  wire logic               sample_valid_i,
   input  wire logic signed [15:0] sense_voltage_with_offset_i,
   input  wire logic signed [7:0]  temperature_c_i,
   input  wire logic [7:0]         battery_voltage_sample_i,
   input  wire logic [11:0]        protector_state_input_i,
   input  wire bca_strap_t         self_discharge_strap_i,
   input  wire logic               display_enable_i,
   input  wire logic               lmd_load_i,
   input  wire logic [6:0]         reg_addr_i,
   input  wire logic               reg_wr_i,
   input  wire logic [7:0]         reg_wdata_i,
   output logic [7:0]              reg_rdata_o,
   output logic                    charge_fet_control_o,
   output logic [4:0]              led_seg_o,
   output logic [15:0]             available_capacity_count_o,
   output logic [7:0]              discharge_tally_o,
   output logic                    capacity_inaccurate_flag_o,
   output logic                    valid_charge_o
);
   bca_comp_if cif ();

   bca_strap_t  strap_r;
   logic        strap_taken_r;
   bca_chg_t    chg_r;
   logic [15:0] nac_r;
   logic [15:0] nac_nxt;
   logic [15:0] lmd_r;
   logic [7:0]  dcr_r;
   logic [16:0] dcr_sum;
   logic [7:0]  flags1;
   logic [7:0]  cpi_r;
   logic [7:0]  cpi_nxt;
   logic        ci_r;
   logic        vdq_r;
   logic        protector_state_input_r;
   logic        high_rate_r;
   logic [7:0]  max_stack_voltage_limit_r;
   logic [23:0] acc_r;
   logic [23:0] acc_sum;
   logic [15:0] dead_r;
   logic [16:0] mag;
   logic        in_chg;
   logic        in_dis;
   logic        cnt_hit;
   logic        chg_cnt;
   logic        dis_cnt;
   logic        filt_to;
   logic        valid_pulse;
   logic        sd_tick;
   logic        sd_do;
   logic        coke;
   logic [15:0] cap;
   logic [25:0] cap_prod;
   logic [2:0]  band;
   logic [15:0] sd_amt;
   logic signed [7:0] temp_q;

   // The strap is static configuration, caught once after reset is released.
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         strap_taken_r <= 1'b0;
         strap_r       <= STRAP_FLOAT;
      end else if (!strap_taken_r) begin
         strap_taken_r <= 1'b1;
         strap_r       <= self_discharge_strap_i; // RQ25
      end
   end

   assign coke  = (strap_r != STRAP_LOW); // RQ25
   assign sd_do = sd_tick && strap_taken_r && (strap_r != STRAP_HIGH); // RQ14

   assign in_chg = sense_voltage_with_offset_i > FILTER_UV; // RQ15
   assign in_dis = sense_voltage_with_offset_i < -FILTER_UV; // RQ15
   assign mag = sense_voltage_with_offset_i[15] ? 17'(-{1'b1, sense_voltage_with_offset_i})
                                                : {1'b0, sense_voltage_with_offset_i};

   // Counts come at a rate proportional to the sense voltage via a magnitude accumulator.
   assign acc_sum = acc_r + 24'(mag);
   assign cnt_hit = sample_valid_i && (in_chg || in_dis) && (acc_sum >= 24'(COUNT_UNIT_UV)); // RQ16
   assign chg_cnt = cnt_hit && in_chg; // RQ1
   assign dis_cnt = cnt_hit && in_dis; // RQ4

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         acc_r <= '0;
      end else if (sample_valid_i && (in_chg || in_dis)) begin
         acc_r <= cnt_hit ? acc_sum - 24'(COUNT_UNIT_UV) : acc_sum;
      end
   end

   assign filt_to = sample_valid_i && !(in_chg || in_dis) && (dead_r == 16'(FILTER_TIMEOUT - 1));

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         dead_r <= '0;
      end else if (sample_valid_i) begin
         dead_r <= ((in_chg || in_dis) || filt_to) ? '0 : dead_r + 16'h0001;
      end
   end

   assign valid_pulse = (chg_r == CHG_QUAL) && chg_cnt; // RQ2

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         chg_r <= CHG_IDLE;
      end else begin
         unique case (chg_r)
            CHG_IDLE: begin
               if (chg_cnt) begin
                  chg_r <= CHG_QUAL;
               end
            end
            CHG_QUAL: begin
               if (dis_cnt || filt_to) begin
                  chg_r <= CHG_IDLE; // RQ2
               end else if (chg_cnt) begin
                  chg_r <= CHG_VALID; // RQ2
               end
            end
            CHG_VALID: begin
               if (sample_valid_i && !in_chg) begin
                  chg_r <= CHG_IDLE; // RQ3
               end
            end
            default: chg_r <= CHG_IDLE;
         endcase
      end
   end

   assign temp_q   = temperature_c_i;
   assign cap_prod = 26'(lmd_r) * 26'(PM_CAP);
   // Cold charge is capped short of full so a learn cycle cannot be qualified.
   assign cap = (temp_q < T_FREEZE) ? 16'(cap_prod / 26'(PM_ONE)) : lmd_r; // RQ11 RQ12

   always_comb begin
      if (temp_q < T_COOL) begin
         band = '0;
      end else if (temp_q >= T_SD_HOT) begin
         band = SD_TOP;
      end else begin
         band = 3'(temp_q / T_SD_BAND);
      end
   end

   // Applied once per day; this trades a coarse daily step for a tiny divider.
   assign sd_amt = nac_r >> (SD_SHIFT0 - {1'b0, band}); // RQ13

   always_comb begin
      nac_nxt = nac_r;
      if (dis_cnt) begin
         nac_nxt = (nac_r == '0) ? '0 : nac_r - 16'h0001; // RQ4
      end else if (chg_cnt && (nac_r < cap)) begin
         nac_nxt = nac_r + 16'h0001; // RQ1 RQ22
      end
      if (sd_do) begin
         nac_nxt = (nac_nxt > sd_amt) ? nac_nxt - sd_amt : '0; // RQ5
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         nac_r <= '0;
      end else begin
         nac_r <= nac_nxt;
      end
   end

   // The sum is wide enough that a large self-discharge step cannot wrap past the saturation test.
   assign dcr_sum = 17'(dcr_r) + 17'(dis_cnt) + ((sd_do && (nac_r != '0)) ? 17'(sd_amt) : 17'h00000);

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         dcr_r <= '0;
      end else if (nac_r == lmd_r) begin
         dcr_r <= '0; // RQ24
      end else begin
         dcr_r <= (dcr_sum > 17'(DCR_MAX)) ? DCR_MAX : dcr_sum[7:0]; // RQ4 RQ5 RQ23
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         lmd_r <= LMD_INIT;
         vdq_r <= 1'b0;
      end else begin
         if (lmd_load_i) begin
            lmd_r <= {8'h00, dcr_r};
         end
         if (nac_r == lmd_r) begin
            vdq_r <= 1'b1; // RQ11
         end else if (lmd_load_i) begin
            vdq_r <= 1'b0;
         end
      end
   end

   // A valid charge in the same cycle as a reload still counts.
   always_comb begin
      cpi_nxt = cpi_r;
      if (lmd_load_i) begin
         cpi_nxt = '0; // RQ20
      end
      if (valid_pulse && (cpi_nxt != CPI_MAX)) begin
         cpi_nxt = cpi_nxt + 8'h01; // RQ20
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         cpi_r <= '0;
         ci_r  <= 1'b0;
      end else begin
         cpi_r <= cpi_nxt;
         ci_r  <= (cpi_nxt >= CI_LIMIT); // RQ21
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         high_rate_r <= 1'b0;
      end else if (sample_valid_i && in_dis && (mag >= 17'(HALF_C_UV))) begin
         high_rate_r <= 1'b1;
      end else if (valid_pulse) begin
         high_rate_r <= 1'b0; // RQ9
      end
   end

   assign cif.available_capacity_count       = nac_r;
   assign cif.last_measured_discharge       = lmd_r;
   assign cif.high_rate = high_rate_r;
   assign cif.coke      = coke;
   assign cif.temp      = temp_q;

   bca_comp u_comp (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .c         (cif.comp)
   );

   bca_day_timer #(.PERIOD(DAY_PERIOD)) u_day (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .tick_o    (sd_tick)
   );

   // Hysteresis between the two levels keeps the flag steady in between.
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         protector_state_input_r <= 1'b0;
      end else if (protector_state_input_i > PROTECTOR_STATE_INPUT_SET_MV) begin
         protector_state_input_r <= 1'b1; // RQ19
      end else if (protector_state_input_i < PROTECTOR_STATE_INPUT_CLR_MV) begin
         protector_state_input_r <= 1'b0; // RQ19
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         max_stack_voltage_limit_r <= MAX_STACK_VOLTAGE_LIMIT_RESET;
      end else if (reg_wr_i && (reg_addr_i == REG_MAX_STACK_VOLTAGE_LIMIT)) begin
         max_stack_voltage_limit_r <= reg_wdata_i; // RQ18
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         charge_fet_control_o <= 1'b0;
      end else begin
         charge_fet_control_o <= !((battery_voltage_sample_i > max_stack_voltage_limit_r) || (temp_q < T_FREEZE)
                                   || (temp_q > T_FET_HI)); // RQ17
      end
   end

   always_comb begin
      flags1            = 8'h00;
      flags1[FLG_CHGS]  = (chg_r != CHG_IDLE);
      flags1[FLG_PROTECTOR_STATE_INPUT] = protector_state_input_r; // RQ19
      flags1[FLG_CI]    = ci_r; // RQ21
      flags1[FLG_VDQ]   = vdq_r;
      flags1[FLG_ONE]   = 1'b1;
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         reg_rdata_o <= '0;
      end else begin
         unique case (reg_addr_i)
            REG_FLAGS1: reg_rdata_o <= flags1; // RQ19
            REG_NAC_HI: reg_rdata_o <= nac_r[15:8];
            REG_NAC_LO: reg_rdata_o <= nac_r[7:0];
            REG_LMD:    reg_rdata_o <= lmd_r[15:8];
            REG_CPI:    reg_rdata_o <= cpi_r;
            REG_VSB:    reg_rdata_o <= battery_voltage_sample_i;
            REG_RATE_TEMP_COMP_CAPACITY:   reg_rdata_o <= cif.rate_temp_comp_capacity[15:8];
            REG_RATE_COMP_CAPACITY:   reg_rdata_o <= cif.rate_comp_capacity[15:8];
            REG_MAX_STACK_VOLTAGE_LIMIT:   reg_rdata_o <= max_stack_voltage_limit_r;
            default:    reg_rdata_o <= '0;
         endcase
      end
   end

   generate
      for (genvar k = 0; k < 5; k++) begin : g_seg
         always_ff @(posedge clk_i) begin
            if (!reset_n_i) begin
               led_seg_o[k] <= 1'b0;
            end else begin
               led_seg_o[k] <= display_enable_i && (chg_r != CHG_IDLE)
                               && ((19'(cif.rate_temp_comp_capacity) * 19'h5) > (19'(lmd_r) * 19'(k))); // RQ1 RQ10
            end
         end
      end
   endgenerate

   assign available_capacity_count_o = nac_r;
   assign discharge_tally_o          = dcr_r;
   assign capacity_inaccurate_flag_o = ci_r;
   assign valid_charge_o             = (chg_r == CHG_VALID);

   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   property p_nac_ceiling;
      nac_r <= lmd_r && !lmd_load_i |=> nac_r <= lmd_r;
   endproperty
   a_nac_ceiling: assert property (p_nac_ceiling) else $error("capacity above full"); // RQ22

   property p_dead_band;
      sample_valid_i && !in_chg && !in_dis && !sd_do |=> nac_r == $past(nac_r);
   endproperty
   a_dead_band: assert property (p_dead_band) else $error("count inside dead band"); // RQ16

   property p_dcr_sat;
      dcr_r == DCR_MAX && nac_r != lmd_r |=> dcr_r == DCR_MAX || nac_r == lmd_r;
   endproperty
   a_dcr_sat: assert property (p_dcr_sat) else $error("tally rolled over"); // RQ23

   property p_dcr_clear;
      nac_r == lmd_r |=> dcr_r == 8'h00;
   endproperty
   a_dcr_clear: assert property (p_dcr_clear) else $error("tally not cleared at full"); // RQ24

   property p_valid_two;
      chg_r == CHG_IDLE ##1 (chg_r == CHG_QUAL && chg_cnt) |=> chg_r == CHG_VALID && cpi_r != 8'h00;
   endproperty
   a_valid_two: assert property (p_valid_two) else $error("valid charge missed"); // RQ2

   property p_dis_dec;
      dis_cnt && nac_r != 16'h0000 && !sd_do |=> nac_r == $past(nac_r) - 16'h0001;
   endproperty
   a_dis_dec: assert property (p_dis_dec) else $error("discharge did not decrement"); // RQ4

   property p_fet_hot;
      temp_q > T_FET_HI |=> !charge_fet_control_o;
   endproperty
   a_fet_hot: assert property (p_fet_hot) else $error("charge FET on when hot"); // RQ17

   property p_cpi_sat;
      cpi_r == CPI_MAX && !lmd_load_i |=> cpi_r == CPI_MAX;
   endproperty
   a_cpi_sat: assert property (p_cpi_sat) else $error("inaccuracy counter wrapped"); // RQ20

   property p_sd_off;
      strap_taken_r && strap_r == STRAP_HIGH && !chg_cnt && !dis_cnt |=> $stable(nac_r);
   endproperty
   a_sd_off: assert property (p_sd_off) else $error("self-discharge while disabled"); // RQ14

   property p_protector_state_input;
      protector_state_input_i > PROTECTOR_STATE_INPUT_SET_MV ##1 protector_state_input_i >= PROTECTOR_STATE_INPUT_CLR_MV |=> protector_state_input_r;
   endproperty
   a_protector_state_input: assert property (p_protector_state_input) else $error("protector flag not set"); // RQ19

endmodule : bca_accounting

//--- logic/bca_pkg.sv
// Shared constants and types of the battery capacity accounting block.
package bca_pkg;

   localparam int unsigned     CLK_HZ     = 20_000_000;
   localparam longint unsigned DAY_S      = 86_400;
   localparam longint unsigned DAY_CYCLES = DAY_S * longint'(CLK_HZ);

   // Dead-band of the magnitude filter in microvolts, both directions.
   localparam logic signed [15:0] FILTER_UV = 16'sh00fa;

   // Register command addresses.
   localparam logic [6:0] REG_FLAGS1 = 7'h01;
   localparam logic [6:0] REG_NAC_HI = 7'h03;
   localparam logic [6:0] REG_LMD    = 7'h05;
   localparam logic [6:0] REG_CPI    = 7'h09;
   localparam logic [6:0] REG_VSB    = 7'h0b;
   localparam logic [6:0] REG_RATE_TEMP_COMP_CAPACITY   = 7'h0d;
   localparam logic [6:0] REG_RATE_COMP_CAPACITY   = 7'h0e;
   localparam logic [6:0] REG_MAX_STACK_VOLTAGE_LIMIT   = 7'h15;
   localparam logic [6:0] REG_NAC_LO = 7'h17;

   // Bit positions in the primary status flags.
   localparam int FLG_CHGS  = 7;
   localparam int FLG_PROTECTOR_STATE_INPUT = 5;
   localparam int FLG_CI    = 4;
   localparam int FLG_VDQ   = 3;
   localparam int FLG_ONE   = 2;

   localparam logic [7:0]  MAX_STACK_VOLTAGE_LIMIT_RESET   = 8'hff;
   localparam logic [7:0]  CPI_MAX      = 8'hff;
   localparam logic [7:0]  CI_LIMIT     = 8'h40;
   localparam logic [7:0]  DCR_MAX      = 8'hff;
   localparam logic [11:0] PROTECTOR_STATE_INPUT_SET_MV = 12'h9c4;
   localparam logic [11:0] PROTECTOR_STATE_INPUT_CLR_MV = 12'h1f4;

   // Temperatures in degrees Celsius; SD_SHIFT0 and SD_TOP are a shift count and a band index.
   localparam logic signed [7:0] T_FREEZE  = 8'sh00;
   localparam logic signed [7:0] T_COOL    = 8'sh0a;
   localparam logic signed [7:0] T_COLD    = 8'shec;
   localparam logic signed [7:0] T_FET_HI  = 8'sh3c;
   localparam logic signed [7:0] T_SD_HOT  = 8'sh46;
   localparam logic signed [7:0] T_SD_BAND = 8'sh0a;
   localparam logic [3:0]        SD_SHIFT0 = 4'hb;
   localparam logic [2:0]        SD_TOP    = 3'h7;

   // Capacity fractions in thousandths of the last measured discharge.
   localparam logic [9:0] PM_ONE     = 10'h3e8;
   localparam logic [9:0] PM_CAP     = 10'h3ac;
   localparam logic [9:0] PM_GR_LOW  = 10'h032;
   localparam logic [9:0] PM_GR_MID  = 10'h096;
   localparam logic [9:0] PM_GR_HIGH = 10'h172;
   localparam logic [9:0] PM_CK_LOW  = 10'h064;
   localparam logic [9:0] PM_CK_MID  = 10'h12c;
   localparam logic [9:0] PM_CK_HIGH = 10'h258;

   typedef enum logic [1:0] {
      STRAP_LOW   = 2'b00,
      STRAP_FLOAT = 2'b01,
      STRAP_HIGH  = 2'b10
   } bca_strap_t;

   typedef enum logic [1:0] {
      CHG_IDLE  = 2'b00,
      CHG_QUAL  = 2'b01,
      CHG_VALID = 2'b10
   } bca_chg_t;

endpackage : bca_pkg

//--- logic/bca_comp_if.sv
// Carrier between the counters and the capacity compensation.
`timescale 1ns/1ps
interface bca_comp_if;
   logic [15:0]       available_capacity_count;
   logic [15:0]       last_measured_discharge;
   logic              high_rate;
   logic              coke;
   logic signed [7:0] temp;
   logic [15:0]       rate_comp_capacity;
   logic [15:0]       rate_temp_comp_capacity;

   modport acct (output available_capacity_count, last_measured_discharge, high_rate, coke, temp, input rate_comp_capacity, rate_temp_comp_capacity);
   modport comp (input available_capacity_count, last_measured_discharge, high_rate, coke, temp, output rate_comp_capacity, rate_temp_comp_capacity);
endinterface : bca_comp_if

//--- logic/bca_day_timer.sv
// Divider that gives one enable pulse per day of clock.
`timescale 1ns/1ps
module bca_day_timer
   import bca_pkg::*;
#(
   parameter longint unsigned PERIOD = DAY_CYCLES
)(
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   output logic      tick_o
);
   localparam int W = $clog2(PERIOD + 1);

   logic [W-1:0] cnt_r;

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         cnt_r  <= '0;
         tick_o <= 1'b0;
      end else begin
         tick_o <= (cnt_r == W'(PERIOD - 1));
         cnt_r  <= (cnt_r == W'(PERIOD - 1)) ? '0 : cnt_r + W'(1);
      end
   end
endmodule : bca_day_timer

//--- logic/bca_comp.sv
// Rate and temperature compensation of the available capacity.
`timescale 1ns/1ps
module bca_comp
   import bca_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   bca_comp_if.comp c
);
   logic [9:0]  rate_pm;
   logic [9:0]  temp_pm;
   logic [15:0] rate_red;
   logic [15:0] temp_red;
   logic [16:0] both_red;

   function automatic logic [15:0] frac(input logic [15:0] v, input logic [9:0] pm);
      logic [25:0] prod;
      prod = 26'(v) * 26'(pm);
      return 16'(prod / 26'(PM_ONE));
   endfunction : frac

   always_comb begin
      rate_pm = '0;
      if (c.high_rate) begin
         rate_pm = c.coke ? PM_CK_LOW : PM_GR_LOW; // RQ7 RQ8
      end
      if (c.temp >= T_COOL) begin
         temp_pm = '0;
      end else if (c.temp >= T_FREEZE) begin
         temp_pm = c.coke ? PM_CK_LOW : PM_GR_LOW; // RQ7 RQ8
      end else if (c.temp > T_COLD) begin
         temp_pm = c.coke ? PM_CK_MID : PM_GR_MID; // RQ7 RQ8
      end else begin
         temp_pm = c.coke ? PM_CK_HIGH : PM_GR_HIGH; // RQ7 RQ8
      end
   end

   assign rate_red = frac(c.last_measured_discharge, rate_pm);
   assign temp_red = frac(c.last_measured_discharge, temp_pm);
   assign both_red = 17'(rate_red) + 17'(temp_red);

   // Both values floor at zero rather than wrapping when the reduction exceeds the count.
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         c.rate_comp_capacity <= '0;
         c.rate_temp_comp_capacity <= '0;
      end else begin
         c.rate_comp_capacity <= (c.available_capacity_count > rate_red) ? c.available_capacity_count - rate_red : '0; // RQ6
         c.rate_temp_comp_capacity <= (17'(c.available_capacity_count) > both_red) ? 16'(17'(c.available_capacity_count) - both_red) : '0; // RQ6
      end
   end
endmodule : bca_comp

//--- sim/bca_protector_model.sv
// Behavioural pack protector that reports its charge path state as a level in millivolts.
`timescale 1ns/1ps
module bca_protector_model (
   input  wire logic        charge_fet_control_i,
   input  wire logic [1:0]  mode_i,
   output logic      [11:0] protector_state_o
);
   // Modes 2 and 3 sit exactly on the thresholds, where the flag must hold its value.
   always_comb begin
      case (mode_i)
         2'h0: protector_state_o = charge_fet_control_i ? 12'hce4 : 12'h000;
         2'h1: protector_state_o = 12'h000;
         2'h2: protector_state_o = 12'h9c4;
         default: protector_state_o = 12'h1f4;
      endcase
   end
endmodule : bca_protector_model

//--- sim/battery_capacity_accounting_tb_top.sv
// Self-checking bench of the capacity accounting core.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
   $display("Error at %0t ns: got %0h expected %0h", $time, g, e); end end
module battery_capacity_accounting_tb_top import bca_pkg::*;;
   logic               clk_i = 1'b0;
   logic               reset_n_i = 1'b0;
   logic               sample_valid = 1'b0;
   logic signed [15:0] sense = 16'sh0000;
   logic signed [7:0]  temp = 8'sh19;
   logic [7:0]         battery_voltage_sample = 8'h00;
   logic [7:0]         wdata = 8'h00;
   logic [6:0]         addr = 7'h00;
   logic               reg_wr = 1'b0;
   logic               lmd_load = 1'b0;
   logic [1:0]         pmode = 2'h0;
   bca_strap_t         strap = STRAP_LOW;
   logic [11:0]        protector_state_input;
   logic [7:0]         rdata;
   logic [7:0]         tally;
   logic [15:0]        available_capacity_count;
   logic [4:0]         led;
   logic               fet;
   logic               ci;
   logic               vc;
   int                 mismatches = 0;
   int                 checked = 0;
   int                 cycles = 0;
   logic [7:0]         fv [6] = '{8'h81, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
   logic signed [7:0]  ftp [6] = '{8'sh19, 8'sh19, -8'sh01, 8'sh3d, 8'sh3c, 8'sh00};
   logic               fe [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
   logic [1:0]         pm [5] = '{2'h0, 2'h2, 2'h3, 2'h1, 2'h2};
   logic [7:0]         pf [5] = '{8'h24, 8'h24, 8'h24, 8'h04, 8'h04};
   logic signed [7:0]  ct [4] = '{8'sh0f, 8'sh05, -8'sh05, -8'sh19};
   logic [7:0]         ce [4] = '{8'h08, 8'h07, 8'h06, 8'h05};
   logic [4:0]         le [4] = '{5'h1f, 5'h1f, 5'h1f, 5'h0f};

   bca_accounting #(.DAY_PERIOD(10000), .FILTER_TIMEOUT(4), .LMD_INIT(16'h0800)) u_bca_accounting (
      .clk_i                       (clk_i),
      .reset_n_i                   (reset_n_i),
      .sample_valid_i              (sample_valid),
      .sense_voltage_with_offset_i (sense),
      .temperature_c_i             (temp),
      .battery_voltage_sample_i    (battery_voltage_sample),
      .protector_state_input_i     (protector_state_input),
      .self_discharge_strap_i      (strap),
      .display_enable_i            (1'b1),
      .lmd_load_i                  (lmd_load),
      .reg_addr_i                  (addr),
      .reg_wr_i                    (reg_wr),
      .reg_wdata_i                 (wdata),
      .reg_rdata_o                 (rdata),
      .charge_fet_control_o        (fet),
      .led_seg_o                   (led),
      .available_capacity_count_o  (available_capacity_count),
      .discharge_tally_o           (tally),
      .capacity_inaccurate_flag_o  (ci),
      .valid_charge_o              (vc)
   );

   bca_protector_model u_bca_protector_model (
      .charge_fet_control_i (fet),
      .mode_i               (pmode),
      .protector_state_o    (protector_state_input)
   );

   initial begin
      forever #25 clk_i = ~clk_i;
   end

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up

   // The whole sequence needs well under half of this, so reaching it means a hang.
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         wrap_up();
      end
   end

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr <= a;
      reg_wr <= 1'b1;
      wdata <= d;
      @(posedge clk_i);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rdc(input logic [6:0] a, input logic [7:0] e);
      @(posedge clk_i);
      addr <= a;
      @(posedge clk_i);
      @(negedge clk_i);
      `CHK(rdata, e)
   endtask : rdc

   task automatic burst(input logic signed [15:0] v, input int n);
      @(posedge clk_i);
      sample_valid <= 1'b1;
      sense <= v;
      repeat (n) @(posedge clk_i);
      sample_valid <= 1'b0;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
   endtask : burst

   task automatic cycle_charge(input int n);
      repeat (n) begin
         burst(-16'sh1000, 2);
         burst(16'sh1000, 2);
         burst(16'sh0064, 1);
      end
   endtask : cycle_charge

   initial begin
      repeat (8) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rdc(REG_MAX_STACK_VOLTAGE_LIMIT, 8'hff);
      rdc(REG_FLAGS1, 8'h24);
      rdc(7'h02, 8'h00);
      wr(REG_MAX_STACK_VOLTAGE_LIMIT, 8'h80);
      rdc(REG_MAX_STACK_VOLTAGE_LIMIT, 8'h80);
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_i);
         battery_voltage_sample <= fv[i];
         temp <= ftp[i];
         repeat (3) @(posedge clk_i);
         @(negedge clk_i);
         `CHK(fet, fe[i])
      end
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_i);
         pmode <= pm[i];
         repeat (2) @(posedge clk_i);
         rdc(REG_FLAGS1, pf[i]);
      end
      @(posedge clk_i);
      pmode <= 2'h0;
      temp <= 8'sh19;
      burst(16'sh1000, 1);
      `CHK(available_capacity_count, 16'h0001)
      `CHK(vc, 1'b0)
      burst(16'sh1000, 1);
      `CHK(vc, 1'b1)
      rdc(REG_CPI, 8'h01);
      rdc(REG_FLAGS1, 8'ha4);
      burst(16'sh00fa, 1);
      `CHK(vc, 1'b0)
      burst(-16'sh00fa, 1);
      `CHK(available_capacity_count, 16'h0002)
      `CHK(tally, 8'h00)
      burst(-16'sh1000, 1);
      `CHK(available_capacity_count, 16'h0001)
      `CHK(tally, 8'h01)
      @(posedge clk_i);
      temp <= -8'sh05;
      burst(16'sh1000, 2000);
      `CHK(available_capacity_count, 16'h0785)
      rdc(REG_FLAGS1, 8'h84);
      @(posedge clk_i);
      temp <= 8'sh19;
      burst(16'sh1000, 200);
      `CHK(available_capacity_count, 16'h0800)
      `CHK(tally, 8'h00)
      rdc(REG_FLAGS1, 8'hac);
      rdc(REG_RATE_COMP_CAPACITY, 8'h08);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         temp <= ct[i];
         repeat (3) @(posedge clk_i);
         rdc(REG_RATE_TEMP_COMP_CAPACITY, ce[i]);
         `CHK(led, le[i])
      end
      @(posedge clk_i);
      temp <= 8'sh19;
      cycle_charge(61);
      rdc(REG_CPI, 8'h3f);
      `CHK(ci, 1'b0)
      cycle_charge(1);
      `CHK(ci, 1'b1)
      cycle_charge(200);
      rdc(REG_CPI, 8'hff);
      burst(-16'sh1000, 300);
      `CHK(tally, 8'hff)
      @(posedge clk_i);
      lmd_load <= 1'b1;
      @(posedge clk_i);
      lmd_load <= 1'b0;
      rdc(REG_CPI, 8'h00);
      `CHK(ci, 1'b0)
      repeat (5000) @(posedge clk_i);
      `CHK(available_capacity_count, 16'h06d1)
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      strap <= STRAP_HIGH;
      repeat (8) @(posedge clk_i);
      reset_n_i <= 1'b1;
      burst(16'sh1000, 1920);
      `CHK(available_capacity_count, 16'h0780)
      burst(-16'sh6400, 1);
      `CHK(led, 5'h00)
      rdc(REG_RATE_COMP_CAPACITY, 8'h06);
      @(posedge clk_i);
      temp <= -8'sh05;
      repeat (3) @(posedge clk_i);
      rdc(REG_RATE_TEMP_COMP_CAPACITY, 8'h04);
      burst(16'sh1000, 2);
      rdc(REG_RATE_COMP_CAPACITY, 8'h07);
      repeat (9000) @(posedge clk_i);
      `CHK(available_capacity_count, 16'h0781)
      burst(16'sh0064, 1);
      burst(16'sh1000, 1);
      burst(16'sh0064, 4);
      burst(16'sh1000, 1);
      `CHK(vc, 1'b0)
      wrap_up();
   end
endmodule : battery_capacity_accounting_tb_top
